// ==== hdl/lpc_pkg.sv ====
// constants, encodings and state types for the line port control and status registers
// assumes one 250 MHz clock and a synchronous, active-high reset shared by all users

package lpc_pkg;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [3:0] PORT_ADDR = 4'h1;
  localparam logic [2:0] SUB_SIGNAL_CONTROL = 3'h1;
  localparam logic [2:0] SUB_TX_ADV_ONE = 3'h2;
  localparam logic [2:0] SUB_TX_ADV_ZERO = 3'h3;
  localparam logic [2:0] SUB_RESERVED_FOUR = 3'h4;
  localparam logic [2:0] SUB_STATUS = 3'h5;
  localparam logic [2:0] SUB_TX_GAIN = 3'h6;
  localparam logic [2:0] SUB_TEST = 3'h7;
  localparam int ADDR_PORT_HI = 7;
  localparam int ADDR_PORT_LO = 4;
  localparam int ADDR_SUB_HI = 3;
  localparam int ADDR_SUB_LO = 1;
  localparam int ADDR_READ_BIT = 0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_INV_BIT = 7;
  localparam int RX_INV_BIT = 6;
  localparam int LOS_OVR_BIT = 5;
  localparam int REMOTE_LB_BIT = 4;
  localparam int LOCAL_LB_BIT = 3;
  localparam int FIFO_RST_BIT = 0;
  localparam int TX_EQ_BIT = 0;
  localparam int BOOST_HI = 2;
  localparam int BOOST_LO = 1;
  localparam int FULL_LB_BIT = 0;
  localparam int RX_LOST_BIT = 4;
  localparam int TX_LOST_BIT = 1;
  localparam int FIFO_ERR_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SIGNAL_CONTROL_RST = 8'h00;
  localparam logic [7:0] TX_ADV_ONE_RST = 8'h00;
  localparam logic [7:0] TX_ADV_ZERO_RST = 8'ha8;
  localparam logic [7:0] RESERVED_FOUR_RST = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] BOOST_NOMINAL = 2'h0;
  localparam logic [1:0] BOOST_FIVE = 2'h1;
  localparam logic [1:0] BOOST_RESERVED = 2'h2;
  localparam logic [1:0] BOOST_TEN = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOS_DETECT_NS = 400;
  localparam int LOS_DETECT_CYCLES = (LOS_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOS_CNT_W = 8;
  localparam logic [LOS_CNT_W-1:0] LOS_CNT_LIMIT = LOS_CNT_W'(LOS_DETECT_CYCLES);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // serial port states, gray along idle, address, load, data
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_ADDR = 2'b01,
    SER_LOAD = 2'b11,
    SER_DATA = 2'b10
  } lpc_ser_state_t;

endpackage

// ==== hdl/lpc_serial_port.sv ====
// four-wire serial port slave: address byte then one data byte, msb first
// assumes pins are asynchronous to clk and sck is far slower than clk

`timescale 1ns/100ps

module lpc_serial_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ser_cs_n,
  input wire logic ser_sck,
  input wire logic ser_sdi,
  input wire logic [7:0] rd_data,
  input wire logic rd_enable,
  output logic ser_sdo,
  output logic ser_sdo_oe_n,
  output logic [7:0] addr_byte,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_r, pin_sync_r;
  logic sck_d_r;
  logic cs_act, sck_s, sdi_s, rise, fall;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_r <= 3'h1;
      pin_sync_r <= 3'h1;
      sck_d_r <= 1'b0;
    end else begin
      pin_meta_r <= {ser_sdi, ser_sck, ser_cs_n};
      pin_sync_r <= pin_meta_r;
      sck_d_r <= pin_sync_r[1];
    end
  end

  assign cs_act = ~pin_sync_r[0];
  assign sck_s = pin_sync_r[1];
  assign sdi_s = pin_sync_r[2];
  assign rise = sck_s & ~sck_d_r;
  assign fall = ~sck_s & sck_d_r;

  // ----------------------------------------------------------------
  // shifter and sequence
  // ----------------------------------------------------------------
  lpc_pkg::lpc_ser_state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, addr_r, addr_nxt, wdat_r, wdat_nxt;
  logic wr_r, wr_nxt, rd_r, rd_nxt, sdo_r, sdo_nxt, oe_n_r, oe_n_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    sdo_nxt = sdo_r;
    oe_n_nxt = oe_n_r;
    if (!cs_act) begin
      state_nxt = lpc_pkg::SER_IDLE;
      cnt_nxt = 3'h0;
      oe_n_nxt = 1'b1;
      sdo_nxt = 1'b0;
    end else begin
      case (state_r)
        lpc_pkg::SER_IDLE: begin
          state_nxt = lpc_pkg::SER_ADDR;
          cnt_nxt = 3'h0;
        end
        lpc_pkg::SER_ADDR: begin
          if (rise) begin
            shift_nxt = {shift_r[6:0], sdi_s};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == lpc_pkg::LAST_BIT) begin
              addr_nxt = {shift_r[6:0], sdi_s};
              // strobe spans the snapshot cycle so no flag event slips between
              rd_nxt = sdi_s;
              state_nxt = lpc_pkg::SER_LOAD;
            end
          end
        end
        lpc_pkg::SER_LOAD: begin
          // read data is captured here, one cycle after the address settles
          shift_nxt = rd_data;
          oe_n_nxt = ~(addr_r[lpc_pkg::ADDR_READ_BIT] & rd_enable);
          cnt_nxt = 3'h0;
          state_nxt = lpc_pkg::SER_DATA;
        end
        lpc_pkg::SER_DATA: begin
          if (addr_r[lpc_pkg::ADDR_READ_BIT]) begin
            if (fall) begin
              sdo_nxt = shift_r[7];
              shift_nxt = {shift_r[6:0], 1'b0};
            end
          end else if (rise) begin
            shift_nxt = {shift_r[6:0], sdi_s};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == lpc_pkg::LAST_BIT) begin
              wdat_nxt = {shift_r[6:0], sdi_s};
              wr_nxt = 1'b1;
              state_nxt = lpc_pkg::SER_ADDR;
            end
          end
        end
        default: begin
          state_nxt = lpc_pkg::SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= lpc_pkg::SER_IDLE;
      cnt_r <= 3'h0;
      shift_r <= 8'h00;
      addr_r <= 8'h00;
      wdat_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      sdo_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      sdo_r <= sdo_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign ser_sdo = sdo_r;
  assign ser_sdo_oe_n = oe_n_r;
  assign addr_byte = addr_r;
  assign wr_data = wdat_r;
  assign wr_stb = wr_r;
  assign rd_stb = rd_r;

endmodule

// ==== hdl/lpc_port_regs.sv ====
// port control and status registers with the digital line path steering they drive
// assumes line data bits come from recovery logic on clk; status conditions come
// from analog detectors and are synchronised here

`timescale 1ns/100ps

module lpc_port_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic soft_register_reset,
  input wire logic ser_cs_n,
  input wire logic ser_sck,
  input wire logic ser_sdi,
  output logic ser_sdo,
  output logic ser_sdo_oe_n,
  input wire logic tx_serial_data_inputs,
  input wire logic rx_line_inputs,
  input wire logic rx_recovered_data,
  input wire logic rx_signal_absent,
  input wire logic tx_input_absent,
  input wire logic fifo_depth_error,
  output logic tx_line_outputs,
  output logic rx_decoder_input,
  output logic tx_recovery_input,
  output logic loss_indicator_output,
  output logic fifo_pointer_reset,
  output logic tx_input_equalizer_enable,
  output logic [1:0] tx_amplitude_boost,
  output logic full_digital_loopback
);

  // ----------------------------------------------------------------
  // status condition synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cond_raw, cond_s;
  assign cond_raw = {fifo_depth_error, tx_input_absent, rx_signal_absent};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic meta_r, sync_r;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= cond_raw[gi];
          sync_r <= meta_r;
        end
      end
      assign cond_s[gi] = sync_r;
    end
  endgenerate

  logic rx_absent_s, tx_absent_s, fifo_depth_error_flag_s;
  assign rx_absent_s = cond_s[0];
  assign tx_absent_s = cond_s[1];
  assign fifo_depth_error_flag_s = cond_s[2];

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  logic [7:0] addr_byte, wr_data, rd_data;
  logic wr_stb, rd_stb, port_hit, rd_enable;
  logic [2:0] sub;

  assign sub = addr_byte[lpc_pkg::ADDR_SUB_HI:lpc_pkg::ADDR_SUB_LO];
  // global and higher port numbers belong elsewhere or are invalid
  assign port_hit = (addr_byte[lpc_pkg::ADDR_PORT_HI:lpc_pkg::ADDR_PORT_LO]
                     == lpc_pkg::PORT_ADDR);
  // sub-address 0 is the mode register, held outside this block
  assign rd_enable = port_hit && (sub != 3'h0);

  lpc_serial_port u_serial (
    .clk(clk),
    .sys_rst(sys_rst),
    .ser_cs_n(ser_cs_n),
    .ser_sck(ser_sck),
    .ser_sdi(ser_sdi),
    .rd_data(rd_data),
    .rd_enable(rd_enable),
    .ser_sdo(ser_sdo),
    .ser_sdo_oe_n(ser_sdo_oe_n),
    .addr_byte(addr_byte),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] sig_ctl_r, sig_ctl_nxt;
  logic [7:0] adv_one_r, adv_one_nxt;
  logic [7:0] adv_zero_r, adv_zero_nxt;
  logic [7:0] rsv_four_r, rsv_four_nxt;
  logic wr_ok;

  assign wr_ok = wr_stb && port_hit;

  always_comb begin
    sig_ctl_nxt = sig_ctl_r;
    adv_one_nxt = adv_one_r;
    adv_zero_nxt = adv_zero_r;
    rsv_four_nxt = rsv_four_r;
    if (soft_register_reset) begin
      sig_ctl_nxt = lpc_pkg::SIGNAL_CONTROL_RST;
      adv_one_nxt = lpc_pkg::TX_ADV_ONE_RST;
      adv_zero_nxt = lpc_pkg::TX_ADV_ZERO_RST;
      rsv_four_nxt = lpc_pkg::RESERVED_FOUR_RST;
    end else if (wr_ok) begin
      case (sub)
        lpc_pkg::SUB_SIGNAL_CONTROL: sig_ctl_nxt = wr_data;
        lpc_pkg::SUB_TX_ADV_ONE: adv_one_nxt = wr_data;
        lpc_pkg::SUB_TX_ADV_ZERO: adv_zero_nxt = wr_data;
        lpc_pkg::SUB_RESERVED_FOUR: rsv_four_nxt = wr_data;
        // status is cleared by reading; 6 and 7 hold nothing to write
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sig_ctl_r <= lpc_pkg::SIGNAL_CONTROL_RST;
      adv_one_r <= lpc_pkg::TX_ADV_ONE_RST;
      adv_zero_r <= lpc_pkg::TX_ADV_ZERO_RST;
      rsv_four_r <= lpc_pkg::RESERVED_FOUR_RST;
    end else begin
      sig_ctl_r <= sig_ctl_nxt;
      adv_one_r <= adv_one_nxt;
      adv_zero_r <= adv_zero_nxt;
      rsv_four_r <= rsv_four_nxt;
    end
  end

  logic tx_inv, rx_inv, los_ovr, remote_lb, local_lb, fifo_rst, full_lb;
  assign tx_inv = sig_ctl_r[lpc_pkg::TX_INV_BIT];
  assign rx_inv = sig_ctl_r[lpc_pkg::RX_INV_BIT];
  assign los_ovr = sig_ctl_r[lpc_pkg::LOS_OVR_BIT];
  assign remote_lb = sig_ctl_r[lpc_pkg::REMOTE_LB_BIT];
  assign local_lb = sig_ctl_r[lpc_pkg::LOCAL_LB_BIT];
  assign fifo_rst = sig_ctl_r[lpc_pkg::FIFO_RST_BIT];
  assign full_lb = adv_zero_r[lpc_pkg::FULL_LB_BIT];

  // ----------------------------------------------------------------
  // loss of signal counter and indicator
  // ----------------------------------------------------------------
  logic [lpc_pkg::LOS_CNT_W-1:0] los_cnt_r, los_cnt_nxt;
  logic los_r, los_nxt;

  always_comb begin
    los_cnt_nxt = los_cnt_r;
    los_nxt = los_r;
    if (los_ovr || soft_register_reset) begin
      los_cnt_nxt = '0;
      los_nxt = 1'b0;
    end else if (!rx_absent_s) begin
      los_cnt_nxt = '0;
      los_nxt = 1'b0;
    end else if (los_cnt_r < lpc_pkg::LOS_CNT_LIMIT) begin
      // a short dropout must last the full window before it counts as loss
      los_cnt_nxt = los_cnt_r + 1'b1;
    end else begin
      los_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      los_cnt_r <= '0;
      los_r <= 1'b0;
    end else begin
      los_cnt_r <= los_cnt_nxt;
      los_r <= los_nxt;
    end
  end

  // ----------------------------------------------------------------
  // latched status flags
  // ----------------------------------------------------------------
  logic rx_lost_r, rx_lost_nxt, tx_lost_r, tx_lost_nxt, fifo_depth_error_flag_r, fifo_depth_error_flag_nxt;
  logic stat_rd;

  assign stat_rd = rd_stb && port_hit && (sub == lpc_pkg::SUB_STATUS);

  always_comb begin
    rx_lost_nxt = rx_lost_r;
    tx_lost_nxt = tx_lost_r;
    fifo_depth_error_flag_nxt = fifo_depth_error_flag_r;
    // a read clears, but a condition present in the same cycle sets again
    if (stat_rd || soft_register_reset) begin
      rx_lost_nxt = 1'b0;
      tx_lost_nxt = 1'b0;
      fifo_depth_error_flag_nxt = 1'b0;
    end
    if (los_r) begin
      rx_lost_nxt = 1'b1;
    end
    if (tx_absent_s) begin
      tx_lost_nxt = 1'b1;
    end
    if (fifo_depth_error_flag_s) begin
      fifo_depth_error_flag_nxt = 1'b1;
    end
    // pointer reset clears the phase error even against a live error
    if (fifo_rst) begin
      fifo_depth_error_flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_lost_r <= 1'b0;
      tx_lost_r <= 1'b0;
      fifo_depth_error_flag_r <= 1'b0;
    end else begin
      rx_lost_r <= rx_lost_nxt;
      tx_lost_r <= tx_lost_nxt;
      fifo_depth_error_flag_r <= fifo_depth_error_flag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = lpc_pkg::ZERO_BYTE;
    case (sub)
      lpc_pkg::SUB_SIGNAL_CONTROL: rd_data = sig_ctl_r;
      lpc_pkg::SUB_TX_ADV_ONE: rd_data = adv_one_r;
      lpc_pkg::SUB_TX_ADV_ZERO: rd_data = adv_zero_r;
      lpc_pkg::SUB_RESERVED_FOUR: rd_data = rsv_four_r;
      lpc_pkg::SUB_STATUS: begin
        rd_data[lpc_pkg::RX_LOST_BIT] = rx_lost_r;
        rd_data[lpc_pkg::TX_LOST_BIT] = tx_lost_r;
        rd_data[lpc_pkg::FIFO_ERR_BIT] = fifo_depth_error_flag_r;
      end
      lpc_pkg::SUB_TX_GAIN: rd_data = lpc_pkg::ZERO_BYTE;
      lpc_pkg::SUB_TEST: rd_data = lpc_pkg::ZERO_BYTE;
      default: rd_data = lpc_pkg::ZERO_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // line path steering and control outputs
  // ----------------------------------------------------------------
  logic tx_out_r, tx_out_nxt, rx_dec_r, rx_dec_nxt, tx_cru_r, tx_cru_nxt;
  logic [1:0] boost_r, boost_nxt;
  logic fifo_rst_r, eq_r, full_lb_r;

  always_comb begin
    // the remote path bypasses tx data only when local loopback is off
    if (remote_lb && !local_lb) begin
      tx_out_nxt = rx_recovered_data ^ tx_inv;
    end else begin
      tx_out_nxt = tx_serial_data_inputs ^ tx_inv;
    end
    if (local_lb) begin
      rx_dec_nxt = tx_serial_data_inputs;
    end else begin
      rx_dec_nxt = rx_line_inputs ^ rx_inv;
    end
    // full loopback is legal only in plesiochronous or loop timing
    tx_cru_nxt = full_lb ? rx_recovered_data : tx_serial_data_inputs;
    case (adv_zero_r[lpc_pkg::BOOST_HI:lpc_pkg::BOOST_LO])
      lpc_pkg::BOOST_FIVE: boost_nxt = lpc_pkg::BOOST_FIVE;
      lpc_pkg::BOOST_TEN: boost_nxt = lpc_pkg::BOOST_TEN;
      // reserved code falls back to nominal so the driver never sees it
      default: boost_nxt = lpc_pkg::BOOST_NOMINAL;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_out_r <= 1'b0;
      rx_dec_r <= 1'b0;
      tx_cru_r <= 1'b0;
      boost_r <= lpc_pkg::BOOST_NOMINAL;
      fifo_rst_r <= 1'b0;
      eq_r <= 1'b0;
      full_lb_r <= 1'b0;
    end else begin
      tx_out_r <= tx_out_nxt;
      rx_dec_r <= rx_dec_nxt;
      tx_cru_r <= tx_cru_nxt;
      boost_r <= boost_nxt;
      fifo_rst_r <= fifo_rst;
      eq_r <= adv_one_r[lpc_pkg::TX_EQ_BIT];
      full_lb_r <= full_lb;
    end
  end

  assign tx_line_outputs = tx_out_r;
  assign rx_decoder_input = rx_dec_r;
  assign tx_recovery_input = tx_cru_r;
  assign loss_indicator_output = los_r;
  assign fifo_pointer_reset = fifo_rst_r;
  assign tx_input_equalizer_enable = eq_r;
  assign tx_amplitude_boost = boost_r;
  assign full_digital_loopback = full_lb_r;

endmodule

// ==== bench/lpc_regs_properties.sv ====
// concurrent checks on the port register block outputs
// assumes it is bound onto lpc_port_regs; one clock, sync reset
`timescale 1ns/100ps
module lpc_regs_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic soft_register_reset,
  input wire logic ser_cs_n,
  input wire logic ser_sck,
  input wire logic ser_sdo,
  input wire logic ser_sdo_oe_n,
  input wire logic tx_serial_data_inputs,
  input wire logic rx_recovered_data,
  input wire logic rx_signal_absent,
  input wire logic tx_line_outputs,
  input wire logic tx_recovery_input,
  input wire logic loss_indicator_output,
  input wire logic fifo_pointer_reset,
  input wire logic tx_input_equalizer_enable,
  input wire logic [1:0] tx_amplitude_boost,
  input wire logic full_digital_loopback
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // --------------------
  // loss run counter
  // --------------------
  logic [7:0] abs_cnt_r, abs_cnt_nxt;
  always_comb begin
    abs_cnt_nxt = (abs_cnt_r == 8'hff) ? abs_cnt_r : abs_cnt_r + 8'h01;
    if (sys_rst || !rx_signal_absent) abs_cnt_nxt = 8'h00;
  end
  always_ff @(posedge clk) begin
    abs_cnt_r <= abs_cnt_nxt;
  end
  // --------------------
  // properties
  // --------------------
  rec_path_a:
    assert property (!$past(sys_rst) |-> tx_recovery_input == (full_digital_loopback ?
      $past(rx_recovered_data) : $past(tx_serial_data_inputs))) else $error("recovery path");
  los_set_a:
    assert property ($rose(loss_indicator_output) |-> abs_cnt_r >= 8'h64)
      else $error("loss set early");
  los_drop_a:
    assert property ($fell(rx_signal_absent) |-> ##[1:5] !loss_indicator_output)
      else $error("loss not dropped");
  sdo_idle_a:
    assert property (ser_cs_n [*4] |-> ser_sdo_oe_n) else $error("sdo driven idle");
  sdo_hold_a:
    assert property (ser_sck [*8] |-> $stable(ser_sdo)) else $error("sdo moved");
  boost_code_a:
    assert property (tx_amplitude_boost != 2'h2) else $error("reserved boost");
  soft_defaults_a:
    assert property (soft_register_reset |=> ##1 (!full_digital_loopback &&
      !tx_input_equalizer_enable && tx_amplitude_boost == 2'h0 && !fifo_pointer_reset))
      else $error("soft reset values");
  rst_outputs_a:
    assert property ($past(sys_rst) |-> !tx_line_outputs && !loss_indicator_output &&
      ser_sdo_oe_n && !full_digital_loopback) else $error("reset outputs");
  cover property ($rose(loss_indicator_output));
  cover property ($fell(ser_sdo_oe_n));
  cover property ($rose(full_digital_loopback));
endmodule
bind lpc_port_regs lpc_regs_properties lpc_regs_properties_inst (.clk, .sys_rst,
  .soft_register_reset, .ser_cs_n, .ser_sck, .ser_sdo, .ser_sdo_oe_n,
  .tx_serial_data_inputs, .rx_recovered_data, .rx_signal_absent, .tx_line_outputs,
  .tx_recovery_input, .loss_indicator_output, .fifo_pointer_reset,
  .tx_input_equalizer_enable, .tx_amplitude_boost, .full_digital_loopback);

// ==== bench/lpc_host_model.sv ====
// host controller on the four-wire serial port
// assumes sck phases of ten clk cycles; sdi toggles after the last bit and an undriven sdo reads inverted
`timescale 1ns/100ps
module lpc_host_model (
  input wire logic clk,
  output logic ser_cs_n,
  output logic ser_sck,
  output logic ser_sdi,
  input wire logic ser_sdo,
  input wire logic ser_sdo_oe_n
);
  localparam int HALF = 10;
  logic drove;
  initial begin
    ser_cs_n = 1'b1;
    ser_sck = 1'b0;
    ser_sdi = 1'b0;
    drove = 1'b0;
  end
  task automatic bit_io(input logic b, output logic q);
    ser_sck = 1'b0;
    ser_sdi = b;
    repeat (HALF) @(negedge clk);
    ser_sck = 1'b1;
    q = (ser_sdo_oe_n === 1'b0) ? ser_sdo : ~ser_sdo;
    if (ser_sdo_oe_n === 1'b0) drove = 1'b1;
    repeat (HALF) @(negedge clk);
  endtask
  // callers reset the fifo after start-up and keep full loopback to
  // plesiochronous use; a plain fifo reset is harmless there
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic u;
    ser_cs_n = 1'b0;
    drove = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 7; i >= 0; i--) bit_io(a[i], u);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    ser_sck = 1'b0;
    ser_sdi = ~ser_sdi;
    repeat (HALF) @(negedge clk);
    ser_cs_n = 1'b1;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the port register block
// assumes the host model drives the serial port on falling clk edges
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst, soft_register_reset, ser_cs_n, ser_sck, ser_sdi, ser_sdo, ser_sdo_oe_n;
  logic tx_serial_data_inputs, rx_line_inputs, rx_recovered_data, rx_signal_absent;
  logic tx_input_absent, fifo_depth_error, tx_line_outputs, rx_decoder_input;
  logic tx_recovery_input, loss_indicator_output, fifo_pointer_reset;
  logic tx_input_equalizer_enable, full_digital_loopback;
  logic [1:0] tx_amplitude_boost;
  int n_mismatch, n_checks;
  lpc_port_regs lpc_port_regs_inst (.clk, .sys_rst, .soft_register_reset, .ser_cs_n,
    .ser_sck, .ser_sdi, .ser_sdo, .ser_sdo_oe_n, .tx_serial_data_inputs, .rx_line_inputs,
    .rx_recovered_data, .rx_signal_absent, .tx_input_absent, .fifo_depth_error,
    .tx_line_outputs, .rx_decoder_input, .tx_recovery_input, .loss_indicator_output,
    .fifo_pointer_reset, .tx_input_equalizer_enable, .tx_amplitude_boost,
    .full_digital_loopback);
  lpc_host_model lpc_host_model_inst (.clk, .ser_cs_n, .ser_sck, .ser_sdi, .ser_sdo,
    .ser_sdo_oe_n);
  always #2 clk = ~clk;
  // --------------------
  // helpers
  // --------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string w);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string w);
    chk_byte({7'h00, got}, {7'h00, exp}, w);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] sub, input logic [7:0] v);
    logic [7:0] q;
    lpc_host_model_inst.frame({lpc_pkg::PORT_ADDR, sub, 1'b0}, v, q);
  endtask
  task automatic rdc(input logic [3:0] p, input logic [2:0] sub, input logic [7:0] exp);
    logic [7:0] q;
    lpc_host_model_inst.frame({p, sub, 1'b1}, 8'h00, q);
    chk_byte(q, exp, "read value");
  endtask
  // --------------------
  // scenarios
  // --------------------
  task automatic t_defaults;
    logic [2:0] s[5] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    logic [7:0] e[5] = '{8'h00, 8'ha8, 8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) rdc(4'h1, s[i], e[i]);
    $display("defaults done");
  endtask
  task automatic t_signal;
    logic [7:0] v[5] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h18};
    logic [2:0] d[5] = '{3'h1, 3'h1, 3'h1, 3'h4, 3'h3};
    logic [1:0] e[5] = '{2'h2, 2'h1, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < 5; i++) begin
      {tx_serial_data_inputs, rx_line_inputs, rx_recovered_data} = d[i];
      wr(3'h1, v[i]);
      chk_bit(tx_line_outputs, e[i][1], "tx line");
      chk_bit(rx_decoder_input, e[i][0], "rx decoder");
      rdc(4'h1, 3'h1, v[i]);
    end
    wr(3'h1, 8'h00);
    $display("signal control done");
  endtask
  task automatic t_adv;
    logic [1:0] e[4] = '{2'h0, 2'h1, 2'h0, 2'h3};
    wr(3'h2, 8'h01);
    chk_bit(tx_input_equalizer_enable, 1'b1, "equalizer");
    rdc(4'h1, 3'h2, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(3'h3, 8'ha8 | 8'(c << 1));
      chk_byte({6'h00, tx_amplitude_boost}, {6'h00, e[c]}, "boost");
    end
    {tx_serial_data_inputs, rx_recovered_data} = 2'h1;
    wr(3'h3, 8'ha9);
    chk_bit(tx_recovery_input, 1'b1, "full loopback");
    chk_bit(full_digital_loopback, 1'b1, "loopback flag");
    wr(3'h3, 8'ha8);
    chk_bit(tx_recovery_input, 1'b0, "no loopback");
    $display("advanced control done");
  endtask
  task automatic t_invalid;
    logic [7:0] q;
    lpc_host_model_inst.frame(8'h22, 8'hff, q);
    rdc(4'h1, 3'h1, 8'h00);
    rdc(4'h2, 3'h1, 8'hff);
    chk_bit(lpc_host_model_inst.drove, 1'b0, "foreign port drove");
    wr(3'h6, 8'hff);
    rdc(4'h1, 3'h6, 8'h00);
    $display("invalid access done");
  endtask
  task automatic t_status;
    rx_signal_absent = 1'b1;
    cyc(120);
    chk_bit(loss_indicator_output, 1'b1, "loss set");
    rx_signal_absent = 1'b0;
    cyc(10);
    rdc(4'h1, 3'h5, 8'h10);
    rdc(4'h1, 3'h5, 8'h00);
    tx_input_absent = 1'b1;
    cyc(4);
    tx_input_absent = 1'b0;
    rdc(4'h1, 3'h5, 8'h02);
    fifo_depth_error = 1'b1;
    cyc(4);
    fifo_depth_error = 1'b0;
    rdc(4'h1, 3'h5, 8'h01);
    wr(3'h1, 8'h01);
    chk_bit(fifo_pointer_reset, 1'b1, "fifo reset");
    fifo_depth_error = 1'b1;
    cyc(4);
    fifo_depth_error = 1'b0;
    rdc(4'h1, 3'h5, 8'h00);
    wr(3'h1, 8'h20);
    chk_bit(fifo_pointer_reset, 1'b0, "fifo reset off");
    rx_signal_absent = 1'b1;
    cyc(120);
    chk_bit(loss_indicator_output, 1'b0, "loss override");
    rx_signal_absent = 1'b0;
    wr(3'h1, 8'h00);
    $display("status done");
  endtask
  task automatic t_soft;
    wr(3'h3, 8'hab);
    soft_register_reset = 1'b1;
    cyc(1);
    soft_register_reset = 1'b0;
    cyc(3);
    chk_bit(full_digital_loopback, 1'b0, "soft loopback");
    rdc(4'h1, 3'h3, 8'ha8);
    $display("soft reset done");
  endtask
  initial begin
    {soft_register_reset, tx_serial_data_inputs, rx_line_inputs} = 3'h0;
    {rx_recovered_data, rx_signal_absent, tx_input_absent, fifo_depth_error} = 4'h0;
    {n_mismatch, n_checks} = 0;
    sys_rst = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    cyc(4);
    wr(3'h1, 8'h01);
    wr(3'h1, 8'h00);
    t_defaults();
    t_signal();
    t_adv();
    t_invalid();
    t_status();
    t_soft();
    finish_test();
  end
  initial begin
    cyc(60000);
    n_mismatch++;
    $display("unexpected %0t watchdog expired", $time);
    finish_test();
  end
endmodule
